/* File: dv/subcarrier_increment_calc_regs_sva.sv */
`timescale 1ns/100ps
module subcarrier_increment_calc_regs_sva
    import sci_pkg::*;
#(
    parameter logic [7:0] VERSION_ID = 8'h5a,
    parameter int         WIN_LOG2   = 24
)(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        ce,
    // pins
    input wire logic        pixClk,
    input wire logic        refClk,
    // register port
    input wire regReq_t     regReq,
    input wire regResp_t    regResp,
    // to subcarrier generation
    input wire logic [31:0] incrementOut,
    input wire logic        freeRunForce
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // the bench leaves one idle cycle between pointer load and access
    sequence selRd(logic [7:0] a);
        ce && regReq.ptrWr && regReq.data == a
        ##1 !regReq.ptrWr && !regReq.wr
        ##1 ce && regReq.rd && !regReq.ptrWr;
    endsequence

    AST_RD_VALID: assert property (ce |=>
        regResp.rdValid == $past(regReq.rd)) else $error("rdValid timing");
    AST_RD_HOLD: assert property (ce && !regReq.rd |=>
        $stable(regResp.rdData)) else $error("rdData changed");
    AST_VERSION: assert property (selRd(8'h25) |=>
        regResp.rdData == VERSION_ID) else $error("version mismatch");
    AST_UNMAPPED: assert property (selRd(8'h30) |=>
        regResp.rdData == 8'h00) else $error("unmapped not zero");
    AST_POINTER: assert property (selRd(8'h3f) |=>
        regResp.rdData == 8'h3f) else $error("pointer readback");
    AST_CTRL_READ: assert property (selRd(8'h21) |=>
        regResp.rdData[7:5] == 3'h0 && regResp.rdData[0] == freeRunForce)
        else $error("control readback");
    AST_AUTO_WRITE: assert property (ce && regReq.ptrWr &&
        regReq.data == 8'h21 ##1 !regReq.ptrWr && !regReq.wr
        ##1 ce && regReq.wr && !regReq.ptrWr ##1 ce |=>
        freeRunForce == $past(regReq.data[0], 2))
        else $error("free-run not following write");
    AST_AUTO_INC: assert property (freeRunForce |->
        incrementOut[5:0] == 6'h00) else $error("auto increment low bits");
    AST_FREEZE: assert property (!ce |=> $stable(incrementOut) &&
        $stable(freeRunForce)) else $error("outputs moved with ce low");

    cover property (selRd(8'h25));
    cover property ($fell(freeRunForce));
    cover property ($rose(freeRunForce));
endmodule : subcarrier_increment_calc_regs_sva

bind subcarrier_increment_calc_regs subcarrier_increment_calc_regs_sva #(
    .VERSION_ID(VERSION_ID),
    .WIN_LOG2  (WIN_LOG2)
) u_subcarrier_increment_calc_regs_sva (
    .clk_sys, .rst_n, .ce, .pixClk, .refClk,
    .regReq, .regResp, .incrementOut, .freeRunForce
);

/* File: dv/subcarrier_increment_calc_regs_test.sv */
`timescale 1ns/100ps
module subcarrier_increment_calc_regs_test
    import sci_pkg::*;
;
    localparam logic [7:0] versionId = 8'h3c; // arbitrary value
    logic        clk_sys = 0, rst_n = 0, ce = 1;
    logic        pixClk = 0, refClk = 0, run = 0;
    regReq_t     regReq = '0;
    regResp_t    regResp;
    logic [31:0] incOut;
    logic        frc;
    logic [7:0]  v;
    logic [2:0]  phase = 3'h0;
    int          miscompares = 0, compares = 0;

    subcarrier_increment_calc_regs #(
        .VERSION_ID(versionId),
        .WIN_LOG2  (4)
    ) u_subcarrier_increment_calc_regs (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pixClk(pixClk), .refClk(refClk),
        .regReq(regReq), .regResp(regResp),
        .incrementOut(incOut), .freeRunForce(frc)
    );

    initial forever #4 clk_sys = ~clk_sys;
    // pins stand still until the meter scenario starts them
    // pixel period 4 clocks, reference 8, changed off the sampling edge
    always @(posedge clk_sys) begin
        #1;
        if (run) begin
            phase = phase + 3'h1;
            pixClk = phase[1];
            refClk = phase[2];
        end
    end

    task automatic final_report();
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // one request held for one edge, then an idle edge before the next
    task automatic op(input logic [2:0] k, input logic [7:0] d);
        @(posedge clk_sys); #1;
        regReq = '{ptrWr: k[2], wr: k[1], rd: k[0], data: d};
        @(posedge clk_sys); #1;
        regReq = '0;
    endtask : op

    task automatic wr(input logic [7:0] a, d);
        op(3'h4, a);
        op(3'h2, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        op(3'h4, a);
        op(3'h1, 8'h00);
        chk("rdValid", regResp.rdValid, 1'b1);
        q = regResp.rdData;
    endtask : rd

    task automatic rdChk(input string n, input logic [7:0] a, e);
        logic [7:0] q;
        rd(a, q);
        chk(n, q, e);
    endtask : rdChk

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1;
        chk("freeRun", frc, 1'b1);
        chk("incOut", incOut, 32'h0);
        rdChk("ctrl", 8'h21, 8'h01);
        rdChk("version", 8'h25, versionId);
        wr(8'h25, 8'hff);
        wr(8'h22, 8'hff);
        wr(8'h21, 8'hfe);
        rdChk("version", 8'h25, versionId);
        rdChk("calcHi", 8'h22, 8'h00);
        rdChk("ctrl", 8'h21, 8'h06);
        chk("freeRun", frc, 1'b0);
        rdChk("pointer", 8'h3f, 8'h3f);
        rdChk("unmapped", 8'h30, 8'h00);
        for (int i = 0; i < 8; i++)
            wr(8'(8'h18 + i), 8'(8'hf1 + i));
        rdChk("incHi", 8'h18, 8'h01);
        chk("incOut", incOut, 32'h12345678);
        // let the last read pulse end before freezing
        @(posedge clk_sys); #1;
        ce = 0;
        op(3'h1, 8'h00);
        chk("rdValid", regResp.rdValid, 1'b0);
        ce = 1;
        // widest hysteresis keeps the result from leaving zero
        run = 1;
        repeat (400) @(posedge clk_sys);
        rdChk("calcLo", 8'h24, 8'h00);
        wr(8'h21, 8'h05);
        v = 8'h00;
        for (int n = 0; n < 50 && v == 8'h00; n++)
            rd(8'h24, v);
        chk("calcRange", 1'(v >= 8'd7 && v <= 8'd9), 1'b1);
        rdChk("calcMid", 8'h23, 8'h00);
        rdChk("ctrl", 8'h21, 8'h05);
        chk("incOut", incOut, {18'h0, v, 6'h00});
        chk("freeRun", frc, 1'b1);
        rst_n = 0;
        @(posedge clk_sys); #1;
        chk("incOut", incOut, 32'h0);
        chk("freeRun", frc, 1'b1);
        rst_n = 1;
        rdChk("ctrl", 8'h21, 8'h01);
        final_report();
    end
endmodule : subcarrier_increment_calc_regs_test

/* File: rtl/pin_sync.sv */
`timescale 1ns/100ps
`include "sci_defs.svh"

module pin_sync
    import sci_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    // pin and result
    input  wire logic pinIn,
    output logic      riseOut
);

    syncState_t r;
    syncState_t n;

    always_comb begin
        n = r;
        n.chain = {r.chain[1:0], pinIn};
        n.rise = 1'b0;
        // stage 0 feeds only stage 1; stages 1 and 2 must agree
        if (r.chain[1] == r.chain[2]) begin
            n.stable = r.chain[2];
            n.rise = r.chain[2] & ~r.stable;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign riseOut = r.rise;

endmodule : pin_sync

/* File: rtl/ratio_meter.sv */
`timescale 1ns/100ps
`include "sci_defs.svh"

module ratio_meter
    import sci_pkg::*;
#(
    parameter int WIN_LOG2 = `SCI_WIN_LOG2
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // qualified clock edges
    input  wire logic        pixRise,
    input  wire logic        refRise,
    // configuration and result
    input  wire logic [1:0]  hystSel,
    output logic      [25:0] calcInc
);

    typedef struct packed {
        logic [WIN_LOG2-1:0] pixCnt;
        logic [25:0]         refCnt;
        logic [25:0]         calc;
    } meterState_t;

    meterState_t r;
    meterState_t n;
    logic [25:0] sample;
    logic [25:0] diff;
    logic [25:0] thresh;

    // reference edges over 2^WIN_LOG2 pixel clocks scale straight to the
    // top 26 bits of the increment, so no divider is needed
    always_comb begin
        n = r;
        sample = r.refCnt;
        if (refRise && (r.refCnt != '1)) begin
            sample = r.refCnt + 26'd1;
        end
        diff = (sample > r.calc) ? (sample - r.calc) : (r.calc - sample);
        case (hystSel)
            2'h0: thresh = `SCI_HYST_T0;
            2'h1: thresh = `SCI_HYST_T1;
            2'h2: thresh = `SCI_HYST_T2;
            default: thresh = `SCI_HYST_T3;
        endcase
        n.refCnt = sample;
        if (pixRise) begin
            n.pixCnt = r.pixCnt + 1'b1;
            if (r.pixCnt == '1) begin
                n.refCnt = '0;
                // small jitter must not toggle the result
                if (diff > thresh) begin
                    n.calc = sample;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{pixCnt: '0, refCnt: '0, calc: `SCI_RST_CALC};
        end else if (ce) begin
            r <= n;
        end
    end

    assign calcInc = r.calc;

endmodule : ratio_meter

/* File: rtl/sci_defs.svh */
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

// register indices on the serial port
`define SCI_ADDR_SWINC_BASE 6'h18
`define SCI_ADDR_SWINC_LAST 6'h1f
`define SCI_ADDR_CTRL       6'h21
`define SCI_ADDR_CALC_HI    6'h22
`define SCI_ADDR_CALC_MID   6'h23
`define SCI_ADDR_CALC_LO    6'h24
`define SCI_ADDR_VERSION    6'h25
`define SCI_ADDR_POINTER    6'h3f

// reset values
`define SCI_RST_AUTO_SEL    1'h1
`define SCI_RST_HYST        2'h0
`define SCI_RST_POINTER     6'h00
`define SCI_RST_SWINC       32'h00000000
`define SCI_RST_CALC        26'h0000000

// field layout of increment_control
`define SCI_CTRL_AUTO_BIT   0
`define SCI_CTRL_HYST_LSB   1
`define SCI_CTRL_HYST_MSB   2

// calculated result is the top of the 32-bit increment
`define SCI_CALC_PAD        6'h00
`define SCI_NIB_ZERO        4'h0
`define SCI_BYTE_ZERO       8'h00

// hysteresis thresholds in calculated-result LSBs (64 increment units), per hysteresis_select
`define SCI_HYST_T0         26'd0
`define SCI_HYST_T1         26'd1
`define SCI_HYST_T2         26'd4
`define SCI_HYST_T3         26'd16

// pixel clocks per measurement window, as a power of two
`define SCI_WIN_LOG2        24

`endif

/* File: rtl/sci_pkg.sv */
package sci_pkg;

    // one request from the serial port front end
    typedef struct packed {
        logic       ptrWr;
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } regReq_t;

    // read answer
    typedef struct packed {
        logic [7:0] rdData;
        logic       rdValid;
    } regResp_t;

    // state of one pin synchroniser
    typedef struct packed {
        logic [2:0] chain;
        logic       stable;
        logic       rise;
    } syncState_t;

    // state of the register slice
    typedef struct packed {
        logic [5:0]  ptr;
        logic        autoSel;
        logic [1:0]  hyst;
        logic [31:0] swInc;
        regResp_t    resp;
        logic [31:0] incOut;
        logic        freeRun;
    } regState_t;

endpackage : sci_pkg

/* File: rtl/subcarrier_increment_calc_regs.sv */
`timescale 1ns/100ps
`include "sci_defs.svh"

module subcarrier_increment_calc_regs
    import sci_pkg::*;
#(
    parameter logic [7:0] VERSION_ID = 8'h5a, // arbitrary value
    parameter int         WIN_LOG2   = `SCI_WIN_LOG2
)(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // clock pins sampled as data
    input  wire logic        pixClk,
    input  wire logic        refClk,
    // serial port front end
    input  wire regReq_t     regReq,
    output regResp_t         regResp,
    // to subcarrier generation
    output logic      [31:0] incrementOut,
    output logic             freeRunForce
);

    regState_t   r;
    regState_t   n;
    logic [1:0]  pinIn;
    logic [1:0]  pinRise;
    logic [25:0] calcInc;
    logic [2:0]  nibIdx;
    logic [3:0]  nibRd;
    logic [7:0]  rdByte;

    assign pinIn = {refClk, pixClk};

    // both clocks are only seen through 125 MHz sampling; pixel clocks
    // faster than about a quarter of that lose edges and corrupt the measurement
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gSync
            pin_sync uSync (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .ce      (ce),
                .pinIn   (pinIn[g]),
                .riseOut (pinRise[g])
            );
        end
    endgenerate

    ratio_meter #(
        .WIN_LOG2 (WIN_LOG2)
    ) uMeter (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .pixRise (pinRise[0]),
        .refRise (pinRise[1]),
        .hystSel (r.hyst),
        .calcInc (calcInc)
    );

    // nibble of subcarrier_increment at the pointer, high nibble first
    always_comb begin
        nibIdx = 3'(r.ptr - `SCI_ADDR_SWINC_BASE);
        nibRd = 4'(r.swInc >> {~nibIdx, 2'b00});
    end

    // readback at the current pointer
    always_comb begin
        if (r.ptr == `SCI_ADDR_CTRL) begin
            rdByte = {3'h0, calcInc[25:24], r.hyst, r.autoSel};
        end else if (r.ptr == `SCI_ADDR_CALC_HI) begin
            rdByte = calcInc[23:16];
        end else if (r.ptr == `SCI_ADDR_CALC_MID) begin
            rdByte = calcInc[15:8];
        end else if (r.ptr == `SCI_ADDR_CALC_LO) begin
            rdByte = calcInc[7:0];
        end else if (r.ptr == `SCI_ADDR_VERSION) begin
            rdByte = VERSION_ID;
        end else if (r.ptr == `SCI_ADDR_POINTER) begin
            rdByte = {2'h0, r.ptr};
        end else if ((r.ptr >= `SCI_ADDR_SWINC_BASE)
                     && (r.ptr <= `SCI_ADDR_SWINC_LAST)) begin
            rdByte = {`SCI_NIB_ZERO, nibRd};
        end else begin
            rdByte = `SCI_BYTE_ZERO;
        end
    end

    always_comb begin
        n = r;
        n.resp.rdValid = 1'b0;
        if (regReq.rd) begin
            n.resp.rdData = rdByte;
            n.resp.rdValid = 1'b1;
        end
        // address phase of the serial port loads the pointer directly
        if (regReq.ptrWr) begin
            n.ptr = regReq.data[5:0];
        end else if (regReq.wr) begin
            if (r.ptr == `SCI_ADDR_CTRL) begin
                // bits 4:3 are the live result and take no write
                n.autoSel = regReq.data[`SCI_CTRL_AUTO_BIT];
                n.hyst = regReq.data[`SCI_CTRL_HYST_MSB:
                                     `SCI_CTRL_HYST_LSB];
            end else if (r.ptr == `SCI_ADDR_POINTER) begin
                n.ptr = regReq.data[5:0];
            end else begin
                for (int i = 0; i < 8; i++) begin
                    if (r.ptr == 6'(`SCI_ADDR_SWINC_BASE + i)) begin
                        n.swInc[(7 - i) * 4 +: 4] = regReq.data[3:0];
                    end
                end
            end
            // result and version registers ignore writes
        end
        if (r.autoSel) begin
            n.incOut = {calcInc, `SCI_CALC_PAD};
        end else begin
            n.incOut = r.swInc;
        end
        n.freeRun = r.autoSel;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{ptr: `SCI_RST_POINTER,
                   autoSel: `SCI_RST_AUTO_SEL,
                   hyst: `SCI_RST_HYST,
                   swInc: `SCI_RST_SWINC,
                   resp: '0,
                   incOut: {`SCI_RST_CALC, `SCI_CALC_PAD},
                   freeRun: `SCI_RST_AUTO_SEL};
        end else if (ce) begin
            r <= n;
        end
    end

    assign regResp = r.resp;
    assign incrementOut = r.incOut;
    assign freeRunForce = r.freeRun;

endmodule : subcarrier_increment_calc_regs
